// ### hw/ucsr_pkg.sv
// Constants shared by the serial control and status block.
// Assumes an 8-bit register port and a receive path sampled by a baud tick.
package ucsr_pkg;

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [3:0] UCSR_OFS_TX_LOW = 4'h2;
    localparam logic [3:0] UCSR_OFS_TX_HIGH = 4'h3;
    localparam logic [3:0] UCSR_OFS_FLAGS = 4'h4;
    localparam logic [3:0] UCSR_OFS_CTRL_A = 4'h5;
    localparam logic [3:0] UCSR_OFS_CTRL_B = 4'h6;
    localparam logic [3:0] UCSR_OFS_CTRL_C = 4'h7;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int UCSR_F_RXC = 7;
    localparam int UCSR_F_TXC = 6;
    localparam int UCSR_F_DRE = 5;
    localparam int UCSR_F_RXS = 4;
    localparam int UCSR_F_ISF = 3;
    localparam int UCSR_F_BDF = 1;
    localparam int UCSR_F_WFB = 0;
    localparam int UCSR_F_LOOPBACK_ENABLE = 3;
    localparam int UCSR_F_RECEIVER_ENABLE = 7;
    localparam int UCSR_F_TRANSMITTER_ENABLE = 6;
    localparam int UCSR_F_START_FRAME_DETECT_ENABLE = 4;
    localparam int UCSR_F_OPEN_DRAIN_ENABLE = 3;
    localparam int UCSR_F_MULTIPROCESSOR_FILTER = 0;

    // --------------------------------------------------------------
    // Reset values and encodings
    // --------------------------------------------------------------
    localparam logic [7:0] UCSR_RST_CTRL = 8'h00;
    localparam logic [1:0] UCSR_LD_OFF = 2'h0;
    localparam logic [1:0] UCSR_LD_EXT = 2'h1;
    localparam logic [1:0] UCSR_LD_INT = 2'h2;
    localparam logic [1:0] UCSR_RX_NORMAL = 2'h0;
    localparam logic [1:0] UCSR_RX_DOUBLE = 2'h1;
    localparam logic [1:0] UCSR_RX_GENAB = 2'h2;
    localparam logic [1:0] UCSR_RX_LINAB = 2'h3;
    localparam logic [1:0] UCSR_CM_ASYNC = 2'h0;
    localparam logic [1:0] UCSR_CM_MASTER_SPI_MODE = 2'h3;
    localparam logic [1:0] UCSR_PM_EVEN = 2'h2;
    localparam logic [1:0] UCSR_PM_ODD = 2'h3;

    // --------------------------------------------------------------
    // Counts in baud samples, bits and edges
    // --------------------------------------------------------------
    localparam logic [4:0] UCSR_SAMPLES_NORMAL = 5'd16;
    localparam logic [4:0] UCSR_SAMPLES_DOUBLE = 5'd8;
    localparam logic [3:0] UCSR_BREAK_BITS = 4'd11;
    localparam logic [4:0] UCSR_LIN_TOL = 5'd3;
    localparam logic [3:0] UCSR_SYNC_EDGES = 4'd8;
    localparam logic [11:0] UCSR_SEG_MIN = 12'd2;
    localparam logic [11:0] UCSR_SEG_MAX = 12'hfff;

    typedef enum logic [3:0] {
        UCSR_AB_IDLE = 4'b0001,
        UCSR_AB_WAIT = 4'b0010,
        UCSR_AB_SYNC = 4'b0100,
        UCSR_AB_FAIL = 4'b1000
    } ucsr_ab_state_t;

endpackage

// ### hw/ucsr_core.sv
// Control and status logic of a serial transceiver: register port, flags,
// enables, pin control, break and autobaud sync checking.
// Assumes the shift registers, baud generator and receive buffer live outside
// on the same clock; only the receive pin is asynchronous.
//
// Notes on behaviour
// - Receive flag follows unread data, clears on one.
// - Transmit flag on frame done, buffer empty.
// - Empty flag high when buffer empty, from reset.
// - Start edge sets flag in standby, wakes.
// - Bad sync sets flag; clearing returns idle.
// - Break is eleven low bits; mode-dependent flag.
// - Wait-for-break takes any low pulse, reads zero.
// - Each enable raises request while flag set.
// - Loop-back ties transmit output to receiver.
// - Line-driver field picks transmit-enable behaviour.
// - Receiver enable owns pin; clearing flushes state.
// - Transmitter release waits for both buffers empty.
// - Open-drain drives low only.
// - Receiver mode: normal, double, two autobaud.
// - Generic sync accepted after eight segments.
// - LIN sync bits within 16 plus-minus 3.
// - Multiprocessor mode discards non-address frames.
// - Communication mode field; SPI changes layout.
// - Parity field: off, even, odd; not SPI.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module ucsr_core
    import ucsr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic rx_unread,
    input wire logic rx_data_received,
    input wire logic rx_frame_end,
    input wire logic rx_frame_address,
    output logic rx_flush,
    output logic rx_frame_discard,
    output logic rx_line,
    input wire logic tx_shift_empty,
    input wire logic tx_buffer_taken,
    input wire logic tx_frame_done,
    input wire logic txc_vector_ack,
    output logic tx_buffer_valid,
    output logic [8:0] tx_buffer_data,
    input wire logic txd_core,
    input wire logic rxd_pin,
    output logic txd_out,
    output logic txd_oe_n,
    output logic transmit_enable_pin,
    output logic rx_pin_owned,
    output logic tx_pin_owned,
    input wire logic sleep_idle,
    input wire logic sleep_standby,
    output logic wake_request,
    input wire logic sample_tick,
    output logic [4:0] samples_per_bit,
    output logic sync_accepted,
    output logic [15:0] sync_length,
    output logic parity_enable,
    output logic parity_odd,
    output logic [1:0] communication_mode,
    output logic [2:0] character_size,
    output logic irq_receive_complete,
    output logic irq_transmit_complete,
    output logic irq_buffer_empty,
    output logic irq_receive_start,
    output logic irq_autobaud_error
);

    // --------------------------------------------------------------
    // Register state
    // --------------------------------------------------------------
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic tx_ninth_bit;
    logic tx_full;
    logic rxc_cleared;
    logic transmit_complete_flag;
    logic receive_start_flag;
    logic inconsistent_sync_flag;
    logic break_detected_flag;
    logic wait_for_break;
    logic tx_active;
    logic rxd_meta;
    logic rxd_sync;
    logic rx_prev;
    ucsr_ab_state_t ab_state;
    logic [7:0] low_count;
    logic [11:0] seg_count;
    logic [3:0] edge_count;
    logic [15:0] total_count;

    logic wr_flags;
    logic wr_one_rxc;
    logic receiver_enable;
    logic transmitter_enable;
    logic start_frame_detect_enable;
    logic open_drain_enable;
    logic loopback_enable;
    logic multiprocessor_filter;
    logic [1:0] line_driver_mode;
    logic [1:0] receiver_speed_mode;
    logic [1:0] parity_mode;
    logic autobaud;
    logic buffer_empty_flag;
    logic receive_complete_flag;
    logic fall_edge;
    logic rise_edge;
    logic break_seen;
    logic seg_bad;
    logic [7:0] break_limit;
    logic [7:0] status_read;

    assign wr_flags = reg_write && (reg_addr == UCSR_OFS_FLAGS);
    assign wr_one_rxc = wr_flags && reg_wdata[UCSR_F_RXC];
    assign receiver_enable = ctrl_b[UCSR_F_RECEIVER_ENABLE];
    assign transmitter_enable = ctrl_b[UCSR_F_TRANSMITTER_ENABLE];
    assign start_frame_detect_enable = ctrl_b[UCSR_F_START_FRAME_DETECT_ENABLE];
    assign open_drain_enable = ctrl_b[UCSR_F_OPEN_DRAIN_ENABLE];
    assign multiprocessor_filter = ctrl_b[UCSR_F_MULTIPROCESSOR_FILTER];
    assign receiver_speed_mode = ctrl_b[2:1];
    assign loopback_enable = ctrl_a[UCSR_F_LOOPBACK_ENABLE];
    assign line_driver_mode = ctrl_a[1:0];
    assign communication_mode = ctrl_c[7:6];
    assign parity_mode = ctrl_c[5:4];
    assign character_size = ctrl_c[2:0];
    assign autobaud = (receiver_speed_mode == UCSR_RX_GENAB) || (receiver_speed_mode == UCSR_RX_LINAB);

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_a <= UCSR_RST_CTRL;
            ctrl_b <= UCSR_RST_CTRL;
            ctrl_c <= UCSR_RST_CTRL;
            tx_ninth_bit <= 1'b0;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                UCSR_OFS_TX_HIGH: tx_ninth_bit <= reg_wdata[0];
                UCSR_OFS_CTRL_A: ctrl_a <= reg_wdata;
                UCSR_OFS_CTRL_B: ctrl_b <= {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
                UCSR_OFS_CTRL_C: ctrl_c <= reg_wdata;
                default: ctrl_a <= ctrl_a;
            endcase
        end
    end

    // Transmit buffer. A low-byte write while the buffer is full is dropped,
    // so a busy transmitter never loses the character it already holds.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_full <= 1'b0;
            tx_buffer_data <= 9'h000;
        end
        else if (reg_write && (reg_addr == UCSR_OFS_TX_LOW) && !tx_full)
        begin
            tx_full <= 1'b1;
            tx_buffer_data <= {tx_ninth_bit, reg_wdata};
        end
        else if (tx_buffer_taken)
        begin
            tx_full <= 1'b0;
        end
    end

    assign tx_buffer_valid = tx_full;
    assign buffer_empty_flag = !tx_full;

    // --------------------------------------------------------------
    // Status flags
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxc_cleared <= 1'b0;
        end
        else if (rx_data_received || !receiver_enable)
        begin
            rxc_cleared <= 1'b0;
        end
        else if (wr_one_rxc)
        begin
            rxc_cleared <= 1'b1;
        end
    end

    assign receive_complete_flag = rx_unread && receiver_enable && !rxc_cleared;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            transmit_complete_flag <= 1'b0;
        end
        else if (tx_frame_done && !tx_full)
        begin
            transmit_complete_flag <= 1'b1;
        end
        else if (txc_vector_ack || (wr_flags && reg_wdata[UCSR_F_TXC]))
        begin
            transmit_complete_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            receive_start_flag <= 1'b0;
        end
        else if (fall_edge && start_frame_detect_enable && sleep_standby && communication_mode != UCSR_CM_MASTER_SPI_MODE)
        begin
            receive_start_flag <= 1'b1;
        end
        else if (wr_flags && reg_wdata[UCSR_F_RXS])
        begin
            receive_start_flag <= 1'b0;
        end
    end

    assign wake_request = fall_edge && start_frame_detect_enable && (sleep_idle || sleep_standby);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            inconsistent_sync_flag <= 1'b0;
        end
        else if (ab_state == UCSR_AB_SYNC && seg_bad)
        begin
            inconsistent_sync_flag <= 1'b1;
        end
        else if (wr_flags && reg_wdata[UCSR_F_ISF])
        begin
            inconsistent_sync_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            break_detected_flag <= 1'b0;
        end
        else if (autobaud ? sync_accepted : break_seen)
        begin
            break_detected_flag <= 1'b1;
        end
        else if ((wr_flags && reg_wdata[UCSR_F_BDF]) || (autobaud && rx_data_received))
        begin
            break_detected_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wait_for_break <= 1'b0;
        end
        else if (wr_flags && reg_wdata[UCSR_F_WFB])
        begin
            wait_for_break <= 1'b1;
        end
        else if (break_seen || !receiver_enable)
        begin
            wait_for_break <= 1'b0;
        end
    end

    // The empty flag position is read-only here, so a stray one written
    // to it by software has no effect.
    assign status_read = {receive_complete_flag, transmit_complete_flag, buffer_empty_flag,
                          receive_start_flag && start_frame_detect_enable, inconsistent_sync_flag,
                          1'b0, break_detected_flag, 1'b0};

    // --------------------------------------------------------------
    // Register reads
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_read)
        begin
            case (reg_addr)
                UCSR_OFS_TX_HIGH: reg_rdata <= {7'h00, tx_ninth_bit};
                UCSR_OFS_FLAGS: reg_rdata <= status_read;
                UCSR_OFS_CTRL_A: reg_rdata <= ctrl_a;
                UCSR_OFS_CTRL_B: reg_rdata <= ctrl_b;
                UCSR_OFS_CTRL_C: reg_rdata <= ctrl_c;
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

    // --------------------------------------------------------------
    // Interrupt requests
    // --------------------------------------------------------------
    assign irq_receive_complete = ctrl_a[7] && receive_complete_flag;
    assign irq_transmit_complete = ctrl_a[6] && transmit_complete_flag;
    assign irq_buffer_empty = ctrl_a[5] && buffer_empty_flag;
    assign irq_receive_start = ctrl_a[4] && receive_start_flag && start_frame_detect_enable;
    assign irq_autobaud_error = ctrl_a[2] && inconsistent_sync_flag;

    // --------------------------------------------------------------
    // Pins
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
        end
        else
        begin
            rxd_meta <= rxd_pin;
            rxd_sync <= rxd_meta;
        end
    end

    assign rx_pin_owned = receiver_enable;
    assign rx_line = loopback_enable ? txd_core : rxd_sync;
    assign rx_flush = !receiver_enable;

    // The transmitter keeps the pin until both buffers drain, so turning it
    // off never truncates a frame already queued.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_active <= 1'b0;
        end
        else if (transmitter_enable)
        begin
            tx_active <= 1'b1;
        end
        else if (!tx_full && tx_shift_empty)
        begin
            tx_active <= 1'b0;
        end
    end

    logic tx_busy;
    logic drive_allowed;
    assign tx_busy = tx_full || !tx_shift_empty;
    assign tx_pin_owned = tx_active;
    assign drive_allowed = tx_active && ((line_driver_mode != UCSR_LD_INT) || tx_busy);
    assign txd_out = open_drain_enable ? 1'b0 : txd_core;
    assign txd_oe_n = !(drive_allowed && !(open_drain_enable && txd_core));
    assign transmit_enable_pin = (line_driver_mode == UCSR_LD_EXT) && tx_active && tx_busy;

    // --------------------------------------------------------------
    // Frame format outputs
    // --------------------------------------------------------------
    assign samples_per_bit = (receiver_speed_mode == UCSR_RX_DOUBLE && communication_mode == UCSR_CM_ASYNC)
                             ? UCSR_SAMPLES_DOUBLE : UCSR_SAMPLES_NORMAL;
    assign parity_enable = (communication_mode != UCSR_CM_MASTER_SPI_MODE)
                           && ((parity_mode == UCSR_PM_EVEN) || (parity_mode == UCSR_PM_ODD));
    assign parity_odd = parity_enable && (parity_mode == UCSR_PM_ODD);
    assign rx_frame_discard = multiprocessor_filter && rx_frame_end && !rx_frame_address;

    // --------------------------------------------------------------
    // Break detection and sync checking
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_prev <= 1'b1;
        end
        else
        begin
            rx_prev <= rx_line;
        end
    end

    assign fall_edge = rx_prev && !rx_line;
    assign rise_edge = !rx_prev && rx_line;
    assign break_limit = 8'(UCSR_BREAK_BITS * samples_per_bit);
    assign break_seen = receiver_enable && rise_edge && (wait_for_break || low_count >= break_limit);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            low_count <= 8'h00;
        end
        else if (rx_line)
        begin
            low_count <= 8'h00;
        end
        else if (sample_tick && low_count != 8'hff)
        begin
            low_count <= low_count + 8'h01;
        end
    end

    // In LIN mode each segment of the sync character must be one bit long,
    // which also proves the character is the alternating pattern.
    always_comb
    begin
        if (receiver_speed_mode == UCSR_RX_LINAB)
        begin
            seg_bad = (rise_edge || fall_edge)
                      && ((seg_count < 12'(samples_per_bit - UCSR_LIN_TOL))
                          || (seg_count > 12'(samples_per_bit + UCSR_LIN_TOL)));
        end
        else
        begin
            seg_bad = ((rise_edge || fall_edge) && seg_count < UCSR_SEG_MIN)
                      || (seg_count == UCSR_SEG_MAX);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ab_state <= UCSR_AB_IDLE;
            seg_count <= 12'h000;
            edge_count <= 4'h0;
            total_count <= 16'h0000;
            sync_accepted <= 1'b0;
            sync_length <= 16'h0000;
        end
        else if (!receiver_enable || !autobaud || communication_mode != UCSR_CM_ASYNC)
        begin
            ab_state <= UCSR_AB_IDLE;
            sync_accepted <= 1'b0;
        end
        else
        begin
            sync_accepted <= 1'b0;
            case (ab_state)
                UCSR_AB_IDLE:
                begin
                    if (break_seen)
                    begin
                        ab_state <= UCSR_AB_WAIT;
                    end
                end
                UCSR_AB_WAIT:
                begin
                    seg_count <= 12'h000;
                    edge_count <= 4'h0;
                    total_count <= 16'h0000;
                    if (fall_edge)
                    begin
                        ab_state <= UCSR_AB_SYNC;
                    end
                end
                UCSR_AB_SYNC:
                begin
                    if (seg_bad)
                    begin
                        ab_state <= UCSR_AB_FAIL;
                    end
                    else if (rise_edge || fall_edge)
                    begin
                        seg_count <= 12'h000;
                        edge_count <= edge_count + 4'h1;
                        if (edge_count + 4'h1 == UCSR_SYNC_EDGES)
                        begin
                            sync_accepted <= 1'b1;
                            sync_length <= total_count;
                            ab_state <= UCSR_AB_IDLE;
                        end
                    end
                    else if (sample_tick)
                    begin
                        seg_count <= seg_count + 12'h001;
                        total_count <= total_count + 16'h0001;
                    end
                end
                UCSR_AB_FAIL:
                begin
                    if (wr_flags && reg_wdata[UCSR_F_ISF])
                    begin
                        ab_state <= UCSR_AB_IDLE;
                    end
                end
                default: ab_state <= UCSR_AB_IDLE;
            endcase
        end
    end

endmodule

`default_nettype wire

// ### bench/ucsr_assertions.sv
// Checker bound to ucsr_core.
// Assumes one clock and reset_n low active.
`timescale 1ns/100ps
`default_nettype none
module ucsr_assertions
    import ucsr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic rx_frame_end,
    input wire logic rx_frame_address,
    input wire logic rx_frame_discard,
    input wire logic rx_flush,
    input wire logic rx_pin_owned,
    input wire logic tx_buffer_taken,
    input wire logic tx_shift_empty,
    input wire logic tx_buffer_valid,
    input wire logic [8:0] tx_buffer_data,
    input wire logic tx_pin_owned,
    input wire logic txd_core,
    input wire logic txd_out,
    input wire logic txd_oe_n,
    input wire logic parity_enable,
    input wire logic [1:0] communication_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_low_write;
        reg_write && reg_addr == UCSR_OFS_TX_LOW && !tx_buffer_valid;
    endsequence
    sequence s_loaded;
        tx_buffer_valid && tx_buffer_data[7:0] == $past(reg_wdata);
    endsequence
    chk_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("stray rdata");
    chk_buffer_load: assert property (s_low_write |=> s_loaded)
        else $error("no load");
    chk_buffer_hold: assert property (tx_buffer_valid && !tx_buffer_taken |=> tx_buffer_valid)
        else $error("buffer lost");
    chk_discard_cause: assert property (rx_frame_discard |-> rx_frame_end && !rx_frame_address)
        else $error("bad discard");
    chk_flush_owner: assert property (rx_flush != rx_pin_owned)
        else $error("flush");
    chk_drain_release: assert property ($fell(tx_pin_owned) |-> $past(tx_shift_empty) && !$past(tx_buffer_valid))
        else $error("early release");
    chk_drive_low: assert property (!txd_oe_n && !txd_out |-> !txd_core)
        else $error("low for one");
    chk_parity_spi: assert property (communication_mode == UCSR_CM_MASTER_SPI_MODE |-> !parity_enable)
        else $error("spi parity");
endmodule
bind ucsr_core ucsr_assertions i_ucsr_assertions (.*);
`default_nettype wire

// ### bench/ucsr_peer.sv
// Far side: transmit shifter and receive line.
// Assumes one clock.
`timescale 1ns/100ps
`default_nettype none
module ucsr_peer (
    input wire logic clk_sys,
    input wire logic tx_buffer_valid,
    output var logic tx_buffer_taken = 1'b0,
    output var logic tx_frame_done = 1'b0,
    output var logic tx_shift_empty = 1'b1,
    output var logic rxd_pin = 1'b1
);
    int frame_len = 12;
    bit stall = 1'b0;
    int left = 0;
    // Stalling keeps the buffer full.
    task automatic drive_low(input int n);
        rxd_pin <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rxd_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys)
    begin
        tx_buffer_taken <= 1'b0;
        tx_frame_done <= 1'b0;
        if (left > 0)
            left <= left - 1;
        if (left == 1)
        begin
            tx_frame_done <= 1'b1;
            tx_shift_empty <= 1'b1;
        end
        if (tx_buffer_valid && tx_shift_empty && !stall && left == 0)
        begin
            tx_buffer_taken <= 1'b1;
            tx_shift_empty <= 1'b0;
            left <= frame_len;
        end
    end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for ucsr_core.
// Assumes the peer and checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ucsr_pkg::*;
    logic clk_sys = 0, reset_n = 0, reg_write = 0, reg_read = 0, rx_unread = 0, rx_data_received = 0;
    logic rx_frame_end = 0, rx_frame_address = 0, txc_vector_ack = 0, txd_core = 1, sleep_idle = 0;
    logic sleep_standby = 0, sample_tick = 1, rx_flush, rx_frame_discard, rx_line, tx_shift_empty;
    logic tx_buffer_taken, tx_frame_done, tx_buffer_valid, txd_out, txd_oe_n, transmit_enable_pin;
    logic rx_pin_owned, tx_pin_owned, wake_request, sync_accepted, parity_enable, parity_odd, rxd_pin;
    logic irq_receive_complete, irq_transmit_complete, irq_buffer_empty, irq_receive_start, irq_autobaud_error;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic [8:0] tx_buffer_data;
    logic [4:0] samples_per_bit;
    logic [15:0] sync_length;
    logic [1:0] communication_mode;
    logic [2:0] character_size;
    int err_total = 0, n_checks = 0, cycles = 0;
    ucsr_core i_ucsr_core (.*);
    ucsr_peer i_ucsr_peer (.*);
    always #2.5 clk_sys = ~clk_sys;
    task automatic test_done();
        $display("checks %0d bad %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys)
        if (++cycles == 4000)
        begin
            err_total++;
            test_done();
        end
    task automatic ck(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    task automatic rk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 ck($sformatf("reg %h", a), reg_rdata, exp);
    endtask
    task automatic wait_txc();
        for (int i = 0; i < 60 && !irq_transmit_complete; i++)
            @(posedge clk_sys);
        #1 ck("txc", irq_transmit_complete, 1);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int a = 3; a < 9; a++)
            rk(a[3:0], (a == 4) ? 8'h20 : 8'h00);
        wr(UCSR_OFS_CTRL_A, 8'hf9);
        wr(UCSR_OFS_CTRL_B, 8'hf9);
        rk(UCSR_OFS_CTRL_A, 8'hf9);
        rk(UCSR_OFS_CTRL_B, 8'hd9);
        ck("irq_dre", irq_buffer_empty, 1);
        @(posedge clk_sys) txd_core <= 1'b0;
        #1 ck("loop", {rx_line, txd_oe_n}, 2'b00);
        @(posedge clk_sys) txd_core <= 1'b1;
        #1 ck("open", {rx_line, txd_out, txd_oe_n}, 3'b101);
        @(posedge clk_sys) rx_frame_end <= 1'b1;
        #1 ck("discard", rx_frame_discard, 1);
        @(posedge clk_sys) rx_frame_address <= 1'b1;
        #1 ck("keep", rx_frame_discard, 0);
        @(posedge clk_sys) rx_frame_end <= 1'b0;
        i_ucsr_peer.stall = 1'b1;
        wr(UCSR_OFS_TX_HIGH, 8'h01);
        wr(UCSR_OFS_TX_LOW, 8'ha5);
        wr(UCSR_OFS_TX_LOW, 8'h3c);
        #1 ck("txbuf", tx_buffer_data, 9'h1a5);
        ck("tepin", transmit_enable_pin, 1);
        rk(UCSR_OFS_FLAGS, 8'h00);
        i_ucsr_peer.stall = 1'b0;
        wait_txc();
        rk(UCSR_OFS_FLAGS, 8'h60);
        wr(UCSR_OFS_FLAGS, 8'h40);
        rk(UCSR_OFS_FLAGS, 8'h20);
        wr(UCSR_OFS_TX_LOW, 8'h5a);
        wait_txc();
        @(posedge clk_sys) txc_vector_ack <= 1'b1;
        @(posedge clk_sys) txc_vector_ack <= 1'b0;
        #1 ck("txc_ack", irq_transmit_complete, 0);
        @(posedge clk_sys) rx_data_received <= 1'b1;
        rx_unread <= 1'b1;
        @(posedge clk_sys) rx_data_received <= 1'b0;
        #1 ck("rxc", irq_receive_complete, 1);
        wr(UCSR_OFS_FLAGS, 8'h80);
        #1 ck("rxc_clr", irq_receive_complete, 0);
        wr(UCSR_OFS_CTRL_B, 8'h00);
        #1 ck("flush", {rx_flush, rx_pin_owned}, 2'b10);
        rx_unread <= 1'b0;
        wr(UCSR_OFS_CTRL_A, 8'h00);
        wr(UCSR_OFS_CTRL_B, 8'h80);
        @(posedge clk_sys) i_ucsr_peer.drive_low(170);
        rk(UCSR_OFS_FLAGS, 8'h20);
        @(posedge clk_sys) i_ucsr_peer.drive_low(182);
        rk(UCSR_OFS_FLAGS, 8'h22);
        wr(UCSR_OFS_FLAGS, 8'h03);
        rk(UCSR_OFS_FLAGS, 8'h20);
        @(posedge clk_sys) i_ucsr_peer.drive_low(20);
        rk(UCSR_OFS_FLAGS, 8'h22);
        for (int v = 0; v < 16; v++)
        begin
            wr(UCSR_OFS_CTRL_C, {v[3:0], 4'h3});
            #1 ck("par", {parity_enable, parity_odd}, (v[3:2] == 2'h3 || !v[1]) ? 2'b00 : {1'b1, v[0]});
        end
        rk(UCSR_OFS_CTRL_C, 8'hf3);
        wr(UCSR_OFS_CTRL_C, 8'h03);
        wr(UCSR_OFS_CTRL_B, 8'h82);
        #1 ck("spb", samples_per_bit, 5'd8);
        test_done();
    end
endmodule
`default_nettype wire
